// ===== core/osc_pkg.sv
// constants, types and field layout for the oscillator switch and reference clock block
// What this block does
// - high byte takes a new source only after keys 78h then 9Ah back to back
// - source field is written only by the access right after the high-byte keys
// - low byte changes only after keys 46h then 57h back to back
// - switch request set right after the low-byte keys starts a source transition
// - switch request clears on success; stays set on failure, lock flag shows cause
// - five sources form eight clock modes, all selectable by software
// - pll multiplies selected sources by four
// - clock-fail monitor detects loss of the system clock
// - half-rate clock pin toggles at half the system clock in every mode
// - reference output works in every oscillator configuration while not in sleep
// - enable bit 15 drives the reference clock onto its pin
// - four-bit divider at bits 11:8 picks one of sixteen ratios
// - source select picks crystal-pin oscillator or system clock
// - sleep-keep bit decides if the reference stays on during sleep
// - sleep output only with sleep-keep, source select and a primary mode
// - source select clear powers the crystal oscillator down in sleep
// - with source select clear the reference follows the system clock
package osc_pkg;

	// ****************************************************************
	// register map and fields
	// ****************************************************************
	localparam logic [3:0]  ADDR_OSC_HIGH    = 4'h0;
	localparam logic [3:0]  ADDR_OSC_LOW     = 4'h1;
	localparam logic [3:0]  ADDR_REFOUT      = 4'h2;
	localparam logic [3:0]  ADDR_STATUS      = 4'h3;
	localparam logic [7:0]  KEY_HIGH_FIRST   = 8'h78;
	localparam logic [7:0]  KEY_HIGH_SECOND  = 8'h9A;
	localparam logic [7:0]  KEY_LOW_FIRST    = 8'h46;
	localparam logic [7:0]  KEY_LOW_SECOND   = 8'h57;
	localparam int          REFOUT_EN_BIT    = 15;
	localparam int          REFOUT_SLP_BIT   = 13;
	localparam int          REFOUT_SEL_BIT   = 12;
	localparam int          REFOUT_DIV_LSB   = 8;
	localparam logic [15:0] REFOUT_RESET     = 16'h0000;
	localparam logic [15:0] REFOUT_MASK      = 16'hBF00;
	localparam logic [2:0]  SOURCE_RESET     = 3'h0;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int          CLK_MHZ          = 40;
	localparam int          SETTLE_US        = 25;
	localparam int          SETTLE_CYCLES    = SETTLE_US * CLK_MHZ;
	localparam int          FAIL_TIMEOUT_NS  = 1000;
	localparam int          FAIL_CYCLES      = FAIL_TIMEOUT_NS * CLK_MHZ / 1000;

	// eight modes built from five sources
	typedef enum logic [2:0] {
		SRC_FAST_RC      = 3'b000,
		SRC_FAST_RC_PLL  = 3'b001,
		SRC_PRIMARY      = 3'b010,
		SRC_PRIMARY_PLL  = 3'b011,
		SRC_SECONDARY    = 3'b100,
		SRC_LOW_RC       = 3'b101,
		SRC_LOW_POWER_RC = 3'b110,
		SRC_FAST_RC_DIV  = 3'b111
	} source_type;

	typedef enum logic [1:0] {
		SW_IDLE   = 2'b00,
		SW_SETTLE = 2'b01,
		SW_SWAP   = 2'b10
	} switch_state_type;

	typedef enum logic [1:0] {
		UNLOCK_NONE  = 2'b00,
		UNLOCK_FIRST = 2'b01,
		UNLOCK_OPEN  = 2'b10
	} unlock_type;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;

	typedef struct packed {
		logic        refout_pin;
		logic        half_rate_clock_pin;
		logic        clock_fail;
		logic        crystal_power;
	} pins_type;

	typedef struct packed {
		unlock_type       high_unlock;
		unlock_type       low_unlock;
		source_type       new_source_select;
		source_type       current_source;
		logic             switch_request;
		logic             switch_failed;
		switch_state_type sw_state;
		logic [10:0]      settle_cnt;
		logic [15:0]      refout_control;
		logic [15:0]      ref_cnt;
		logic             ref_level;
		logic             half_level;
		logic [5:0]       fail_cnt;
		logic             clock_fail;
		logic             clk_ok_seen;
		logic [15:0]      rdata;
	} state_type;

endpackage

// ===== core/osc_switch_refclk_out.sv
// oscillator switch with keyed unlock and divided reference clock output
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module osc_switch_refclk_out (
	// clock and reset
	input  wire  logic                 clk,
	input  wire  logic                 rst_n,
	// register port
	input  wire  osc_pkg::bus_req_type bus,
	output logic [15:0]                rdata,
	// oscillator status and sleep
	input  wire  logic                 source_stable,
	input  wire  logic                 pll_locked,
	input  wire  logic                 crystal_clk,
	input  wire  logic                 clock_alive,
	input  wire  logic                 sleep_mode,
	// pins and controls
	output osc_pkg::pins_type          pins,
	output osc_pkg::source_type        system_source,
	output logic                       pll_enable
);
	import osc_pkg::*;

	state_type s_q;
	state_type s_d;
	logic      primary_mode;
	logic      sleep_ok;
	logic      ref_src;
	logic      ref_tick;
	logic      other_access;

	// ****************************************************************
	// combinational helpers
	// ****************************************************************
	always_comb begin
		primary_mode = (s_q.current_source == SRC_PRIMARY) ||
			(s_q.current_source == SRC_PRIMARY_PLL);
		sleep_ok = s_q.refout_control[REFOUT_SLP_BIT] &&
			s_q.refout_control[REFOUT_SEL_BIT] && primary_mode;
		// crystal pin or system clock feeds the divider
		ref_src = s_q.refout_control[REFOUT_SEL_BIT] ? crystal_clk : 1'b1;
		ref_tick = ref_src && (!sleep_mode || sleep_ok);
		other_access = bus.rd || bus.wr;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		// unlock trackers: any access not matching the next key abandons the sequence
		if (other_access) begin
			s_d.high_unlock = UNLOCK_NONE;
			s_d.low_unlock  = UNLOCK_NONE;
		end
		if (bus.wr && bus.addr == ADDR_OSC_HIGH) begin
			if (s_q.high_unlock == UNLOCK_OPEN) begin
				s_d.new_source_select = source_type'(bus.wdata[2:0]);
			end else if (s_q.high_unlock == UNLOCK_FIRST &&
				bus.wdata[7:0] == KEY_HIGH_SECOND) begin
				s_d.high_unlock = UNLOCK_OPEN;
			end else if (bus.wdata[7:0] == KEY_HIGH_FIRST) begin
				s_d.high_unlock = UNLOCK_FIRST;
			end
		end
		if (bus.wr && bus.addr == ADDR_OSC_LOW) begin
			if (s_q.low_unlock == UNLOCK_OPEN) begin
				if (bus.wdata[0] && s_q.sw_state == SW_IDLE) begin
					s_d.switch_request = 1'b1;
					s_d.switch_failed  = 1'b0;
					s_d.sw_state       = SW_SETTLE;
					s_d.settle_cnt     = 11'h000;
				end
			end else if (s_q.low_unlock == UNLOCK_FIRST &&
				bus.wdata[7:0] == KEY_LOW_SECOND) begin
				s_d.low_unlock = UNLOCK_OPEN;
			end else if (bus.wdata[7:0] == KEY_LOW_FIRST) begin
				s_d.low_unlock = UNLOCK_FIRST;
			end
		end
		if (bus.wr && bus.addr == ADDR_REFOUT) begin
			s_d.refout_control = bus.wdata & REFOUT_MASK;
		end
		// switch sequencer keeps the old source until the new one settles
		case (s_q.sw_state)
			SW_IDLE: begin
				s_d.settle_cnt = 11'h000;
			end
			SW_SETTLE: begin
				if (source_stable) begin
					s_d.sw_state = SW_SWAP;
				end else if (s_q.settle_cnt == 11'(SETTLE_CYCLES - 1)) begin
					s_d.sw_state      = SW_IDLE;
					s_d.switch_failed = 1'b1;
				end else begin
					s_d.settle_cnt = s_q.settle_cnt + 11'h001;
				end
			end
			SW_SWAP: begin
				s_d.sw_state = SW_IDLE;
				if ((s_q.new_source_select == SRC_FAST_RC_PLL ||
					s_q.new_source_select == SRC_PRIMARY_PLL) && !pll_locked) begin
					s_d.switch_failed = 1'b1;
				end else begin
					s_d.current_source = s_q.new_source_select;
					s_d.switch_request = 1'b0;
				end
			end
			default: begin
				s_d.sw_state = SW_IDLE;
			end
		endcase
		// reference divider: field n flips the level every 2^n ticks, so all sixteen ratios differ
		s_d.ref_cnt = s_q.ref_cnt;
		if (!s_q.refout_control[REFOUT_EN_BIT]) begin
			s_d.ref_cnt   = 16'h0000;
			s_d.ref_level = 1'b0;
		end else if (ref_tick) begin
			if (s_q.ref_cnt >=
				(16'h0001 << s_q.refout_control[REFOUT_DIV_LSB +: 4]) - 16'h0001) begin
				s_d.ref_cnt   = 16'h0000;
				s_d.ref_level = !s_q.ref_level;
			end else begin
				s_d.ref_cnt = s_q.ref_cnt + 16'h0001;
			end
		end
		s_d.half_level = !s_q.half_level;
		// clock-fail monitor: watchdog on the alive strobe
		if (clock_alive) begin
			s_d.fail_cnt    = 6'h00;
			s_d.clk_ok_seen = 1'b1;
		end else if (s_q.fail_cnt == 6'(FAIL_CYCLES - 1)) begin
			s_d.clock_fail = s_q.clk_ok_seen;
		end else begin
			s_d.fail_cnt = s_q.fail_cnt + 6'h01;
		end
		// read data, one cycle later
		s_d.rdata = 16'h0000;
		if (bus.rd) begin
			case (bus.addr)
				ADDR_OSC_HIGH: s_d.rdata = {5'h00, s_q.current_source, 5'h00, s_q.new_source_select};
				ADDR_OSC_LOW:  s_d.rdata = {15'h0000, s_q.switch_request};
				ADDR_REFOUT:   s_d.rdata = s_q.refout_control;
				ADDR_STATUS:   s_d.rdata = {12'h000, s_q.clock_fail, s_q.switch_failed,
					pll_locked, s_q.switch_request};
				default:       s_d.rdata = 16'h0000;
			endcase
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q                   <= '0;
			s_q.refout_control    <= REFOUT_RESET;
			s_q.new_source_select <= source_type'(SOURCE_RESET);
			s_q.current_source    <= source_type'(SOURCE_RESET);
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign rdata                    = s_q.rdata;
	assign system_source            = s_q.current_source;
	assign pll_enable = (s_q.current_source == SRC_FAST_RC_PLL) ||
		(s_q.current_source == SRC_PRIMARY_PLL) ||
		(s_q.new_source_select == SRC_FAST_RC_PLL) ||
		(s_q.new_source_select == SRC_PRIMARY_PLL);
	assign pins.refout_pin          = s_q.ref_level && s_q.refout_control[REFOUT_EN_BIT];
	assign pins.half_rate_clock_pin = s_q.half_level;
	assign pins.clock_fail          = s_q.clock_fail;
	assign pins.crystal_power = !sleep_mode || sleep_ok;

	// ****************************************************************
	// checks
	// ****************************************************************
	// a disabled divider must come out of the next edge with its level low
	a_refout_off_disabled: assert property (@(posedge clk) disable iff (!rst_n)
		!s_q.refout_control[REFOUT_EN_BIT] |=> !s_q.ref_level)
		else $error("reference divider running while disabled");
	a_switch_needs_key: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_q.switch_request) |-> $past(s_q.low_unlock) == UNLOCK_OPEN)
		else $error("switch started without unlock");
	a_source_needs_key: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(s_q.new_source_select) |-> $past(s_q.high_unlock) == UNLOCK_OPEN)
		else $error("source changed without unlock");
	a_unlock_abandon: assert property (@(posedge clk) disable iff (!rst_n)
		(other_access && !(bus.wr && bus.addr == ADDR_OSC_HIGH)) |=>
		s_q.high_unlock == UNLOCK_NONE)
		else $error("unlock survived foreign access");
	a_switch_done_clr: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(s_q.current_source) |-> !s_q.switch_request)
		else $error("request not cleared on success");
	a_swap_after_stable: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(s_q.current_source) |-> $past(s_q.sw_state) == SW_SWAP)
		else $error("source swapped before stable");
	a_half_rate_toggle: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.half_level |=> !s_q.half_level ##1 s_q.half_level)
		else $error("half rate pin not toggling");
	a_crystal_sleep_off: assert property (@(posedge clk) disable iff (!rst_n)
		(sleep_mode && !s_q.refout_control[REFOUT_SEL_BIT]) |-> !pins.crystal_power)
		else $error("crystal powered in sleep");
	c_switch_ok: cover property (@(posedge clk) disable iff (!rst_n)
		$fell(s_q.switch_request));
	c_switch_fail: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(s_q.switch_failed));
	c_ref_sleep: cover property (@(posedge clk) disable iff (!rst_n)
		sleep_mode && pins.refout_pin);
endmodule

// ===== tb/osc_switch_refclk_out_test.sv
// self-checking bench for the oscillator switch and reference output block
`timescale 1ns/1ps
module osc_switch_refclk_out_test;
	import osc_pkg::*;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic        clk;
	logic        rst_n;
	bus_req_type bus;
	logic [15:0] rdata;
	logic        source_stable;
	logic        pll_locked;
	logic        crystal_clk;
	logic        clock_alive;
	logic        sleep_mode;
	pins_type    pins;
	source_type  system_source;
	logic        pll_enable;
	logic        alive_stop;
	int          mismatches;
	int          checks_done;
	int          cycles = 0;
	int          seed;
	logic [15:0] v;
	logic        p0;
	logic        p1;
	logic [15:0] sent_q[$];

	osc_switch_refclk_out dut (
		.clk          (clk),
		.rst_n        (rst_n),
		.bus          (bus),
		.rdata        (rdata),
		.source_stable(source_stable),
		.pll_locked   (pll_locked),
		.crystal_clk  (crystal_clk),
		.clock_alive  (clock_alive),
		.sleep_mode   (sleep_mode),
		.pins         (pins),
		.system_source(system_source),
		.pll_enable   (pll_enable)
	);

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// random crystal ticks; heartbeat every cycle until stopped
	always @(posedge clk) begin
		crystal_clk <= 1'($random(seed));
		clock_alive <= !alive_stop;
		cycles      <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			complete_run();
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// every bus cycle is launched just after an edge and held for one edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		#1;
		chk(rdata, exp);
	endtask

	// drop both strobes and let n edges pass
	task automatic idle(input int n);
		bus <= '0;
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic do_switch(input logic [15:0] src);
		wr(ADDR_OSC_HIGH, 16'h0078);
		wr(ADDR_OSC_HIGH, 16'h009A);
		wr(ADDR_OSC_HIGH, src);
		wr(ADDR_OSC_LOW, 16'h0046);
		wr(ADDR_OSC_LOW, 16'h0057);
		wr(ADDR_OSC_LOW, 16'h0001);
	endtask

	// bounded wait for the system source to reach a value
	task automatic wait_src(input logic [2:0] s);
		for (int i = 0; i < 40 && system_source !== s; i++) begin
			@(posedge clk);
			#1;
		end
		chk({13'h0000, system_source}, {13'h0000, s});
	endtask

	task automatic do_reset();
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		@(posedge clk);
		#1;
	endtask

	task automatic complete_run();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		bus = '0;
		source_stable = 1'b0;
		pll_locked = 1'b0;
		sleep_mode = 1'b0;
		alive_stop = 1'b0;
		mismatches = 0;
		checks_done = 0;
		seed = 25981;
		do_reset();
		rd(ADDR_REFOUT, 16'h0000);
		rd(ADDR_STATUS, 16'h0000);
		// random control values; the model keeps what the writable mask lets through
		for (int i = 0; i < 4; i++) begin
			v = 16'($random(seed));
			sent_q.push_back(v & REFOUT_MASK);
			wr(ADDR_REFOUT, v);
			rd(ADDR_REFOUT, sent_q.pop_front());
		end
		// source write without keys, then keys split by a read
		wr(ADDR_OSC_HIGH, 16'h0002);
		rd(ADDR_OSC_HIGH, 16'h0000);
		wr(ADDR_OSC_HIGH, 16'h0078);
		rd(ADDR_STATUS, 16'h0000);
		wr(ADDR_OSC_HIGH, 16'h009A);
		wr(ADDR_OSC_HIGH, 16'h0002);
		rd(ADDR_OSC_HIGH, 16'h0000);
		// full switch; request holds until the new source is stable
		do_switch(16'h0002);
		rd(ADDR_STATUS, 16'h0001);
		rd(ADDR_OSC_HIGH, 16'h0002);
		source_stable <= 1'b1;
		idle(1);
		wait_src(3'h2);
		rd(ADDR_STATUS, 16'h0000);
		rd(ADDR_OSC_HIGH, 16'h0202);
		// pll source without lock fails and keeps the request
		do_switch(16'h0003);
		idle(12);
		rd(ADDR_STATUS, 16'h0005);
		chk({13'h0000, system_source}, 16'h0002);
		// second reset clears the reference control, then pll switch with lock
		idle(1);
		do_reset();
		rd(ADDR_REFOUT, 16'h0000);
		pll_locked <= 1'b1;
		do_switch(16'h0003);
		idle(1);
		wait_src(3'h3);
		chk({15'h0000, pll_enable}, 16'h0001);
		rd(ADDR_STATUS, 16'h0002);
		// divide field zero on the system clock toggles each cycle
		wr(ADDR_REFOUT, 16'h8000);
		idle(3);
		p0 = pins.refout_pin;
		idle(1);
		p1 = pins.refout_pin;
		chk({15'h0000, p0 ^ p1}, 16'h0001);
		p0 = pins.half_rate_clock_pin;
		idle(1);
		chk({15'h0000, p0 ^ pins.half_rate_clock_pin}, 16'h0001);
		// divide field one: exactly one toggle in any two cycles
		wr(ADDR_REFOUT, 16'h8100);
		idle(1);
		p0 = pins.refout_pin;
		idle(2);
		chk({15'h0000, p0 ^ pins.refout_pin}, 16'h0001);
		// sleep with source select clear stops crystal and divider
		sleep_mode <= 1'b1;
		idle(1);
		chk({15'h0000, pins.crystal_power}, 16'h0000);
		p0 = pins.refout_pin;
		idle(2);
		chk({15'h0000, p0 ^ pins.refout_pin}, 16'h0000);
		wr(ADDR_REFOUT, 16'hB000);
		chk({15'h0000, pins.crystal_power}, 16'h0001);
		rd(4'h7, 16'h0000);
		// heartbeat loss beyond the fail window
		alive_stop <= 1'b1;
		idle(FAIL_CYCLES + 10);
		chk({15'h0000, pins.clock_fail}, 16'h0001);
		rd(ADDR_STATUS, 16'h000A);
		complete_run();
	end
endmodule
